// *** include/oatl_pkg.sv ***
package oatl_pkg;
  // ------------------------------------------------------------
  // Temperature coding
  // ------------------------------------------------------------
  localparam int          TEMP_W          = 8;
  localparam int          TEMP_OFFSET_C   = 40;
  localparam int          TEMP_STEPS_PER_C = 2;
  localparam int          NO_SENSOR_C     = 15;
  localparam logic [7:0]  DEFAULT_CODE    = 8'((NO_SENSOR_C + TEMP_OFFSET_C) * TEMP_STEPS_PER_C);

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int          CLK_MHZ         = 200;
  localparam int          START_TIME_MS   = 7000;
  localparam int          START_CYCLES    = START_TIME_MS * CLK_MHZ * 1000;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_STATUS      = 8'h04;
  localparam logic [7:0]  REG_IRQ_STAT    = 8'h08;
  localparam logic [7:0]  REG_IRQ_MASK    = 8'h0C;
  localparam logic [7:0]  REG_DEFAULT     = 8'h10;
  localparam logic [7:0]  REG_QUAL        = 8'h14;
  localparam logic [7:0]  REG_EST         = 8'h18;

  localparam logic [0:0]  CTRL_RESET      = 1'h1;
  localparam int          CTRL_TX_EN_BIT  = 0;

  localparam int          ST_AVAIL_BIT    = 0;
  localparam int          ST_CORR_OK_BIT  = 1;
  localparam int          ST_TX_RUN_BIT   = 2;
  localparam int          ST_EST_INV_BIT  = 3;
  localparam int          ST_MASK_BIT     = 4;
  localparam int          ST_USABLE_BIT   = 5;

  localparam int          IRQ_W           = 4;
  localparam int          IRQ_COMM_LOST   = 0;
  localparam int          IRQ_CORR_INV    = 1;
  localparam int          IRQ_TX_START    = 2;
  localparam int          IRQ_TIMEOUT     = 3;
  localparam logic [3:0]  IRQ_MASK_RESET  = 4'h0;

  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_WAIT = 3'b010,
    TX_RUN  = 3'b100
  } oatl_tx_state_t;
endpackage

// *** rtl/oatl_link.sv ***
`timescale 1ns/10ps
module oatl_link
  import oatl_pkg::*;
#(
  parameter int unsigned START_LIMIT = START_CYCLES  // Start deadline in cycles
) (
  input  wire logic        aclk,              // 200 MHz clock
  input  wire logic        aresetn,           // Sync reset, low
  input  wire logic [7:0]  s_axi_awaddr,      // Write address
  input  wire logic        s_axi_awvalid,     // Write address valid
  output logic             s_axi_awready,     // Write address ready
  input  wire logic [31:0] s_axi_wdata,       // Write data
  input  wire logic [3:0]  s_axi_wstrb,       // Write strobes
  input  wire logic        s_axi_wvalid,      // Write data valid
  output logic             s_axi_wready,      // Write data ready
  output logic [1:0]       s_axi_bresp,       // Write response
  output logic             s_axi_bvalid,      // Write response valid
  input  wire logic        s_axi_bready,      // Write response ready
  input  wire logic [7:0]  s_axi_araddr,      // Read address
  input  wire logic        s_axi_arvalid,     // Read address valid
  output logic             s_axi_arready,     // Read address ready
  output logic [31:0]      s_axi_rdata,       // Read data
  output logic [1:0]       s_axi_rresp,       // Read response
  output logic             s_axi_rvalid,      // Read data valid
  input  wire logic        s_axi_rready,      // Read data ready
  input  wire logic        rx_corr_strobe,    // Corrected message received
  input  wire logic [7:0]  rx_corr_code,      // Corrected temperature code
  input  wire logic        rx_corr_invalid,   // Validity flag, 1 = invalid
  input  wire logic        rx_avail,          // Availability flag, 1 = available
  input  wire logic        comm_lost,         // Gateway communication lost
  input  wire logic        engine_run,        // Engine running indication
  input  wire logic        accessory_mode,    // Accessory power mode
  input  wire logic        sensor_fail,       // Estimator input sensor failed
  input  wire logic        dtc_recorded,      // Matching trouble code recorded
  input  wire logic        accuracy_ok,       // Estimate accuracy achievable
  input  wire logic        est_strobe,        // New estimate available
  input  wire logic [7:0]  est_code,          // New estimate code
  input  wire logic        nv_restore,        // Load estimate from storage
  input  wire logic [7:0]  nv_restore_code,   // Stored estimate code
  output logic             nv_wr_en,          // Storage write pulse
  output logic [7:0]       nv_wr_data,        // Storage write data
  output logic             tx_active,         // Estimate being transmitted
  output logic [7:0]       tx_est_code,       // Transmitted estimate code
  output logic             tx_est_invalid,    // Estimate validity, 1 = invalid
  output logic             tx_est_mask,       // Estimate mask, 1 = use
  output logic [7:0]       qual_temp,         // Qualified outside temperature
  output logic             data_usable,       // Corrected data usable
  output logic             substitute,        // Availability lost, default temperature in use
  output logic             irq                // Level interrupt
);

  // ------------------------------------------------------------
  // Register bus slave
  // ------------------------------------------------------------
  logic                 awready_q, wready_q, bvalid_q, aw_full_q, w_full_q;
  logic                 arready_q, rvalid_q;
  logic [1:0]           bresp_q, rresp_q;
  logic [31:0]          rdata_q, wdata_q;
  logic [3:0]           wstrb_q;
  logic [7:0]           awaddr_q;
  logic                 wr_fire;
  logic                 ctrl_tx_en_q;
  logic [IRQ_W-1:0]     irq_stat_q, irq_mask_q, irq_set;
  logic [7:0]           default_q;
  logic                 avail_q, corr_ok_q, est_inv_q, mask_q;
  logic [7:0]           corr_q, est_q, qual_q;
  logic                 usable_q, subst_q, nv_wr_q, irq_q;
  logic                 run_d1_q, comm_d1_q;
  logic [31:0]          start_cnt_q;
  oatl_tx_state_t       tx_state_q;

  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      aw_full_q <= 1'b0;
      awaddr_q  <= 8'h00;
    end else if (s_axi_awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_full_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_full_q <= 1'b0;
    end else if (!aw_full_q) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b0;
      w_full_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_full_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_full_q <= 1'b0;
    end else if (!w_full_q) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (awaddr_q == REG_CTRL || awaddr_q == REG_IRQ_STAT ||
                   awaddr_q == REG_IRQ_MASK || awaddr_q == REG_DEFAULT) ? RESP_OKAY
                                                                      : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL:     rdata_q <= {31'h0000_0000, ctrl_tx_en_q};
        REG_STATUS:   rdata_q <= {26'h000_0000, usable_q, mask_q, est_inv_q,
                                  tx_state_q == TX_RUN, corr_ok_q, avail_q};
        REG_IRQ_STAT: rdata_q <= {28'h000_0000, irq_stat_q};
        REG_IRQ_MASK: rdata_q <= {28'h000_0000, irq_mask_q};
        REG_DEFAULT:  rdata_q <= {24'h00_0000, default_q};
        REG_QUAL:     rdata_q <= {24'h00_0000, qual_q};
        REG_EST:      rdata_q <= {24'h00_0000, est_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q) begin
      if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end else begin
      arready_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Software registers and interrupts
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_tx_en_q <= CTRL_RESET[0];
      irq_mask_q   <= IRQ_MASK_RESET;
      default_q    <= DEFAULT_CODE;
    end else if (wr_fire && wstrb_q[0]) begin
      case (awaddr_q)
        REG_CTRL:     ctrl_tx_en_q <= wdata_q[CTRL_TX_EN_BIT];
        REG_IRQ_MASK: irq_mask_q   <= wdata_q[IRQ_W-1:0];
        REG_DEFAULT:  default_q    <= wdata_q[7:0];
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    irq_set                = '0;
    irq_set[IRQ_COMM_LOST] = comm_lost && !comm_d1_q;
    irq_set[IRQ_CORR_INV]  = rx_corr_strobe && rx_corr_invalid && !comm_lost;
    irq_set[IRQ_TX_START]  = tx_state_q == TX_WAIT && (est_strobe || start_cnt_q >= START_LIMIT);
    irq_set[IRQ_TIMEOUT]   = tx_state_q == TX_WAIT && !est_strobe && start_cnt_q >= START_LIMIT;
  end

  // New events win over a simultaneous write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
      irq_q      <= 1'b0;
    end else begin
      if (wr_fire && wstrb_q[0] && awaddr_q == REG_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~wdata_q[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat_q <= irq_stat_q | irq_set;
      end
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ------------------------------------------------------------
  // Receive side: corrected temperature and availability
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      avail_q   <= 1'b1;
      corr_ok_q <= 1'b0;
      corr_q    <= DEFAULT_CODE;
      comm_d1_q <= 1'b0;
    end else begin
      comm_d1_q <= comm_lost;
      if (comm_lost) begin
        avail_q <= 1'b0;
      end else if (rx_corr_strobe) begin
        avail_q   <= rx_avail;
        corr_ok_q <= !rx_corr_invalid;
        if (!rx_corr_invalid) begin
          corr_q <= rx_corr_code;
        end
      end
    end
  end

  // Registered so every output stays a flop; adds one cycle of latency
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      qual_q   <= DEFAULT_CODE;
      usable_q <= 1'b0;
      subst_q  <= 1'b0;
    end else begin
      usable_q <= avail_q && corr_ok_q;
      subst_q  <= !avail_q;
      qual_q   <= (avail_q && corr_ok_q) ? corr_q : default_q;
    end
  end

  // ------------------------------------------------------------
  // Transmit side: estimate, flags and start deadline
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      est_inv_q <= 1'b0;
      mask_q    <= 1'b0;
    end else begin
      est_inv_q <= sensor_fail && dtc_recorded;
      mask_q    <= accuracy_ok && !accessory_mode;
    end
  end

  // Only running-engine estimates reach storage, so accessory mode keeps the last one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      est_q   <= DEFAULT_CODE;
      nv_wr_q <= 1'b0;
    end else begin
      nv_wr_q <= engine_run && est_strobe;
      if (engine_run && est_strobe) begin
        est_q <= est_code;
      end else if (nv_restore) begin
        est_q <= nv_restore_code;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state_q  <= TX_IDLE;
      start_cnt_q <= 32'h0000_0000;
      run_d1_q    <= 1'b0;
    end else begin
      run_d1_q <= engine_run;
      case (tx_state_q)
        TX_IDLE: begin
          start_cnt_q <= 32'h0000_0000;
          if (ctrl_tx_en_q && engine_run && !run_d1_q) begin
            tx_state_q <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          start_cnt_q <= start_cnt_q + 32'h0000_0001;
          if (!ctrl_tx_en_q) begin
            tx_state_q <= TX_IDLE;
          end else if (est_strobe || start_cnt_q >= START_LIMIT) begin
            tx_state_q <= TX_RUN;
          end
        end
        TX_RUN: begin
          if (!ctrl_tx_en_q) begin
            tx_state_q <= TX_IDLE;
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign s_axi_awready  = awready_q;
  assign s_axi_wready   = wready_q;
  assign s_axi_bvalid   = bvalid_q;
  assign s_axi_bresp    = bresp_q;
  assign s_axi_arready  = arready_q;
  assign s_axi_rvalid   = rvalid_q;
  assign s_axi_rdata    = rdata_q;
  assign s_axi_rresp    = rresp_q;
  assign nv_wr_en       = nv_wr_q;
  assign nv_wr_data     = est_q;
  assign tx_active      = tx_state_q[2];
  assign tx_est_code    = est_q;
  assign tx_est_invalid = est_inv_q;
  assign tx_est_mask    = mask_q;
  assign qual_temp      = qual_q;
  assign data_usable    = usable_q;
  assign substitute     = subst_q;
  assign irq            = irq_q;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_avail_loss:   assert property (comm_lost |=> !avail_q)
    else $error("availability not dropped on comm loss");
  a_corr_ignore:  assert property (rx_corr_strobe && rx_corr_invalid |=> $stable(corr_q))
    else $error("invalid corrected value was taken");
  a_corr_hold:    assert property (comm_lost |=> $stable(corr_q))
    else $error("corrected value changed during comm loss");
  a_subst_temp:   assert property (!avail_q |=> qual_q == $past(default_q) && subst_q)
    else $error("default not substituted");
  a_usable_drop:  assert property (comm_lost |=> ##1 !usable_q)
    else $error("data usable after comm loss");
  a_mask_acc:     assert property (accessory_mode |=> !mask_q)
    else $error("mask not do-not-use in accessory mode");
  a_mask_acc_ok:  assert property (accuracy_ok && !accessory_mode |=> mask_q)
    else $error("mask not use with accuracy met");
  a_est_invalid:  assert property (sensor_fail && dtc_recorded |=> est_inv_q)
    else $error("estimate not flagged invalid");
  a_start_bound:  assert property (tx_state_q == TX_WAIT |-> start_cnt_q <= START_LIMIT)
    else $error("estimate start deadline overrun");
  a_nv_store:     assert property (engine_run && est_strobe |=> est_q == $past(est_code) && nv_wr_q)
    else $error("estimate not stored");

  c_start_strobe: cover property (tx_state_q == TX_WAIT && est_strobe ##1 tx_state_q == TX_RUN);
  c_start_tmo:    cover property (irq_set[IRQ_TIMEOUT] ##1 tx_state_q == TX_RUN);
  c_comm_lost:    cover property (usable_q ##1 comm_lost ##2 subst_q);
endmodule

// *** dv/oatl_gw_model.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// Gateway side of the outside air temperature link
// ------------------------------------------------------------
module oatl_gw_model
  import oatl_pkg::*;
(
  input  wire logic       aclk,            // Clock
  input  wire logic       aresetn,         // Sync reset, low
  input  wire logic       send,            // Frame request
  input  wire logic       fitted,          // Sensor present
  input  wire logic       sensor_ok,       // Sensor healthy
  input  wire logic       coolant_seen,    // Coolant temperature received
  input  wire logic       link_down,       // Network lost
  input  wire logic [7:0] raw_code,        // Sensor code
  output logic            rx_corr_strobe,  // Frame strobe
  output logic [7:0]      rx_corr_code,    // Corrected code
  output logic            rx_corr_invalid, // 1 = invalid
  output logic            rx_avail,        // 1 = available
  output logic            comm_lost        // Link lost
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_corr_strobe  <= 1'b0;
      rx_corr_code    <= 8'h00;
      rx_corr_invalid <= 1'b1;
      rx_avail        <= 1'b0;
    end else if (send && coolant_seen && !link_down) begin
      rx_corr_strobe  <= 1'b1;
      rx_corr_code    <= fitted ? raw_code : DEFAULT_CODE;
      rx_corr_invalid <= fitted && !sensor_ok;
      rx_avail        <= fitted;
    end else begin
      // Outside frames the strobe is held low and the other lines carry junk, never the previous cycle's value
      rx_corr_strobe  <= 1'b0;
      rx_corr_code    <= ~rx_corr_code;
      rx_corr_invalid <= ~rx_corr_invalid;
      rx_avail        <= ~rx_avail;
    end
  end
  assign comm_lost = link_down;
endmodule

// *** dv/tb.sv ***
`timescale 1ns/10ps
module tb;
  import oatl_pkg::*;
  localparam int LIM = 20;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, gw_send = 0, fitted = 1, sens_ok = 1;
  logic        coolant = 0, link_down = 0, eng_run = 0, acc_mode = 0, s_fail = 0;
  logic        diagnostic_trouble_code = 0, acc_ok = 0, est_stb = 0, nv_rst = 0;
  logic [7:0]  awaddr = 0, araddr = 0, raw_code = 0, est_code = 0, nv_code = 0;
  logic [31:0] wdata = 0;
  logic [3:0]  wstrb = 0;
  logic        awready, wready, bvalid, arready, rvalid, corr_stb, corr_inv, avail;
  logic        comm_lost, nv_wr_en, tx_active, tx_inv, tx_mask, usable, subst, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  corr_code, nv_wr_data, tx_code, qual_temp;
  int          error_cnt = 0, num_checks = 0;

  always #2.5 aclk = ~aclk;

  oatl_gw_model oatl_gw_model_inst (.aclk(aclk), .aresetn(aresetn), .send(gw_send),
    .fitted(fitted), .sensor_ok(sens_ok), .coolant_seen(coolant), .link_down(link_down),
    .raw_code(raw_code), .rx_corr_strobe(corr_stb), .rx_corr_code(corr_code),
    .rx_corr_invalid(corr_inv), .rx_avail(avail), .comm_lost(comm_lost));

  oatl_link #(.START_LIMIT(LIM)) oatl_link_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_corr_strobe(corr_stb), .rx_corr_code(corr_code), .rx_corr_invalid(corr_inv),
    .rx_avail(avail), .comm_lost(comm_lost), .engine_run(eng_run),
    .accessory_mode(acc_mode), .sensor_fail(s_fail), .dtc_recorded(diagnostic_trouble_code),
    .accuracy_ok(acc_ok), .est_strobe(est_stb), .est_code(est_code), .nv_restore(nv_rst),
    .nv_restore_code(nv_code), .nv_wr_en(nv_wr_en), .nv_wr_data(nv_wr_data),
    .tx_active(tx_active), .tx_est_code(tx_code), .tx_est_invalid(tx_inv),
    .tx_est_mask(tx_mask), .qual_temp(qual_temp), .data_usable(usable),
    .substitute(subst), .irq(irq));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (n < 100) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk(32'(n < 100), 32'h1, "write answered");
    chk(32'(bresp), 32'(er), "bresp");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (n < 100) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    chk(rdata, exp, "rdata");
    chk(32'(rresp), 32'(er), "rresp");
  endtask

  task automatic frame(input logic [7:0] c);
    @(posedge aclk);
    raw_code <= c;
    gw_send  <= 1'b1;
    @(posedge aclk);
    gw_send  <= 1'b0;
    settle(5);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    chk(32'(qual_temp), 32'h6E, "qual at reset");
    rd(REG_CTRL, 32'h1, RESP_OKAY);
    rd(REG_STATUS, 32'h1, RESP_OKAY);
    rd(REG_IRQ_MASK, 32'h0, RESP_OKAY);
    rd(REG_DEFAULT, 32'h6E, RESP_OKAY);
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(REG_QUAL, 32'h5, RESP_SLVERR);
    $display("test reset done");
  endtask

  task automatic t_rx;
    logic [7:0] codes [3];
    codes = '{8'h00, 8'hFF, 8'h50};
    frame(8'h10);
    chk(32'(qual_temp), 32'h6E, "no coolant yet");
    @(posedge aclk);
    coolant <= 1'b1;
    foreach (codes[i]) begin
      frame(codes[i]);
      chk(32'(qual_temp), 32'(codes[i]), "code passes");
      chk(32'(usable), 32'h1, "usable");
    end
    @(posedge aclk);
    sens_ok <= 1'b0;
    frame(8'h22);
    chk(32'(qual_temp), 32'h6E, "invalid ignored");
    chk(32'(usable), 32'h0, "invalid unusable");
    chk(32'(irq), 32'h0, "masked irq");
    rd(REG_IRQ_STAT, 32'h2, RESP_OKAY);
    wr(REG_IRQ_MASK, 32'h2, RESP_OKAY);
    settle(3);
    chk(32'(irq), 32'h1, "irq raised");
    wr(REG_IRQ_STAT, 32'h2, RESP_OKAY);
    settle(3);
    chk(32'(irq), 32'h0, "irq cleared");
    wr(REG_IRQ_MASK, 32'h0, RESP_OKAY);
    sens_ok <= 1'b1;
    $display("test receive done");
  endtask

  task automatic t_loss;
    wr(REG_DEFAULT, 32'h20, RESP_OKAY);
    frame(8'h60);
    @(posedge aclk);
    link_down <= 1'b1;
    settle(5);
    chk(32'(subst), 32'h1, "lost -> substitute");
    chk(32'(qual_temp), 32'h20, "default used");
    rd(REG_IRQ_STAT, 32'h1, RESP_OKAY);
    wr(REG_IRQ_STAT, 32'hF, RESP_OKAY);
    link_down <= 1'b0;
    frame(8'h61);
    chk(32'(subst), 32'h0, "restored");
    chk(32'(qual_temp), 32'h61, "new value");
    @(posedge aclk);
    fitted <= 1'b0;
    frame(8'h99);
    chk(32'(subst), 32'h1, "no sensor");
    chk(32'(qual_temp), 32'h20, "no sensor default");
    rd(REG_STATUS, 32'h2, RESP_OKAY);
    fitted <= 1'b1;
    $display("test loss done");
  endtask

  task automatic t_flags;
    for (int i = 0; i < 16; i++) begin
      @(posedge aclk);
      {s_fail, diagnostic_trouble_code, acc_ok, acc_mode} <= 4'(i);
      settle(3);
      chk(32'(tx_inv), 32'(s_fail & diagnostic_trouble_code), "est invalid");
      chk(32'(tx_mask), 32'(acc_ok & ~acc_mode), "est mask");
      chk(32'(!tx_inv && tx_mask),
          32'(!(s_fail & diagnostic_trouble_code) && acc_ok && !acc_mode), "estimate usable");
    end
    $display("test flags done");
  endtask

  task automatic t_tx;
    int n;
    int seen;
    n = 0;
    seen = 0;
    @(posedge aclk);
    nv_rst  <= 1'b1;
    nv_code <= 8'h33;
    @(posedge aclk);
    nv_rst  <= 1'b0;
    settle(3);
    chk(32'(tx_code), 32'h33, "restored estimate");
    rd(REG_EST, 32'h33, RESP_OKAY);
    wr(REG_IRQ_STAT, 32'hF, RESP_OKAY);
    eng_run <= 1'b1;
    settle(5);
    chk(32'(tx_active), 32'h0, "waiting");
    while (tx_active !== 1'b1 && n < LIM + 10) begin
      settle(1);
      n++;
    end
    chk(32'(tx_active), 32'h1, "started by deadline");
    chk(32'(n + 5), 32'(LIM + 2), "start cycle count");
    rd(REG_IRQ_STAT, 32'hC, RESP_OKAY);
    @(posedge aclk);
    est_stb  <= 1'b1;
    est_code <= 8'h44;
    @(posedge aclk);
    est_stb  <= 1'b0;
    #1;
    repeat (4) begin
      if (nv_wr_en === 1'b1) seen++;
      settle(1);
    end
    chk(32'(seen), 32'h1, "one store pulse");
    chk(32'(nv_wr_data), 32'h44, "stored value");
    chk(32'(tx_code), 32'h44, "sent value");
    @(posedge aclk);
    eng_run <= 1'b0;
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    settle(2);
    chk(32'(tx_active), 32'h0, "disabled stops");
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    wr(REG_IRQ_STAT, 32'hF, RESP_OKAY);
    eng_run <= 1'b1;
    repeat (3) @(posedge aclk);
    est_stb  <= 1'b1;
    est_code <= 8'h55;
    @(posedge aclk);
    est_stb  <= 1'b0;
    settle(2);
    chk(32'(tx_active), 32'h1, "started by estimate");
    chk(32'(tx_code), 32'h55, "new estimate sent");
    rd(REG_IRQ_STAT, 32'h4, RESP_OKAY);
    eng_run <= 1'b0;
    $display("test transmit done");
  endtask

  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Whole run needs a few hundred cycles; the 20000-cycle limit allows ample margin
  initial begin
    #100000;
    error_cnt++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    settle(1);
    t_reset();
    t_rx();
    t_loss();
    t_flags();
    t_tx();
    complete_run();
  end
endmodule
